/* File: hdl/pcw_cfg.svh */
/* Constants of the power, clock and watchdog controller: register offsets,
   field positions, reset values and timing figures.
   Assumes a 250 MHz system clock and a byte-addressed APB bus.
// Contract
// - Active state keeps the processor running and all peripherals usable.
// - Idle: processor waits for interrupt, fast core clock slowed, all else kept.
// - Sleep stops all clocks but the slow one; wakes on interval or pin.
// - Sleep: fast core clock off, regulators at low voltage, state retained.
// - Power-down sleep: radio and most logic off; RAM, registers kept.
// - Extended power-down sleep keeps only main RAM and its control powered.
// - Deep-off powers down core, radio, regulators; wakes on pin or time.
// - Leaving deep-off forces full init but keeps exit flag and wake cause.
// - Deep-off stops internal slow oscillators and clock; external input times wake.
// - Power state changes start only from firmware, not from hardware alone.
// - Watchdog interrupts firmware after 2 s without service.
// - Watchdog resets the device after 4 s without service.
// - Firmware selects slow clock among two internal oscillators and a crystal.
// - Fast system clock comes from the 24 MHz crystal oscillator.
// - Slow external input takes 32 kHz or 32.768 kHz crystal or driven clock.
// - Debug access to flash and RAM is disabled at power-up.
// - Lockout field keeps debug memory access off and blocks raw reads.
// - Flash code fetches go through an 8 KB cache.
*/
`ifndef PCW_CFG_SVH
`define PCW_CFG_SVH
`define PCW_CLK_MHZ 250
`define PCW_WDT_IRQ_MS 2000
`define PCW_WDT_RST_MS 4000
`define PCW_WDT_W 30
`define PCW_XTAL_KHZ 24000
`define PCW_SLOW_HZ 32768
`define PCW_CACHE_KB 8
`define PCW_A_MODE 12'h000
`define PCW_A_STAT 12'h004
`define PCW_A_CLK 12'h008
`define PCW_A_WIVL 12'h00c
`define PCW_A_WDOG 12'h010
`define PCW_A_LOCK 12'h014
`define PCW_A_WAKE 12'h018
`define PCW_A_PMSK 12'h01c
`define PCW_MC_ACT 3'h0
`define PCW_MC_IDLE 3'h1
`define PCW_MC_SLP 3'h2
`define PCW_MC_PWDN 3'h3
`define PCW_MC_XPWDN 3'h4
`define PCW_MC_DOFF 3'h5
`define PCW_CLK_RST 8'h42
`define PCW_CLK_SRC 1:0
`define PCW_CLK_BYP 2
`define PCW_CLK_DIV 7:4
`define PCW_WAKE_DOFF 0
`define PCW_WAKE_PIN 1
`define PCW_WAKE_TMR 2
`endif

/* File: hdl/pcw_ctrl.sv */
/* Power state, slow clock selection, wake timer, debug lockout and
   watchdog control with an APB register slave.
   Assumes oscillator, wake pin and lockout inputs are asynchronous,
   IRQ_PEND_I comes from the same clock, and the power switches obey
   the registered enables below. */
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "pcw_cfg.svh"
module pcw_ctrl #(
  parameter int unsigned NPIN = 4,
  parameter int unsigned WDT_IRQ_CYC = `PCW_WDT_IRQ_MS * `PCW_CLK_MHZ * 1000,
  parameter int unsigned WDT_RST_CYC = `PCW_WDT_RST_MS * `PCW_CLK_MHZ * 1000
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Slow clock sources and wake events
  input wire logic LOW_CURRENT_INTERNAL_OSC_I,
  input wire logic HIGH_ACCURACY_INTERNAL_OSC_I,
  input wire logic EXTERNAL_SLOW_CRYSTAL_I,
  input wire logic [NPIN-1:0] WAKE_PIN_I,
  input wire logic IRQ_PEND_I,
  input wire logic LOCKOUT_I,
  // Processor and clocks
  output logic CPU_RUN_O,
  output logic WAIT_FOR_INTERRUPT_STATE_O,
  output logic PERIPH_EN_O,
  output logic HCLK_EN_O,
  output logic [3:0] HCLK_DIV_O,
  output logic XTAL_EN_O,
  output logic [1:0] SLOW_CLOCK_SEL_O,
  output logic EXT_BYPASS_O,
  output logic LP_OSC_EN_O,
  output logic HP_OSC_EN_O,
  output logic EXT_OSC_EN_O,
  output logic RTC_EN_O,
  output logic CACHE_EN_O,
  // Power domains
  output logic REG_LOWV_O,
  output logic RADIO_PWR_O,
  output logic CORE_PWR_O,
  output logic RET_PWR_O,
  output logic RAM_PWR_O,
  output logic FULL_INIT_O,
  // Watchdog and debug
  output logic WDT_IRQ_O,
  output logic WDT_RST_O,
  output logic DBG_MEM_EN_O,
  output logic HCI_RAW_BLOCK_O
);
  localparam int unsigned CACHE_BYTES = `PCW_CACHE_KB * 1024;

  pcw_pkg::pcw_state_t state_reg, state_next;
  pcw_pkg::pcw_pwr_t pwr_reg;
  pcw_wdt_if wif ();

  logic [2:0] mode_reg;
  logic [7:0] clk_reg;
  logic [31:0] wivl_reg;
  logic [31:0] tmr_reg;
  logic [2:0] wake_reg;
  logic [NPIN-1:0] pmsk_reg;
  logic dbg_reg;
  logic blk_reg;
  logic init_reg;
  logic [3:0] div_reg;
  logic [31:0] rdata_reg;
  logic [2:0] osc_s1_reg, osc_s2_reg;
  logic tick_prev_reg;
  logic [NPIN-1:0] pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic lock_s1_reg, lock_s2_reg;
  logic [7:0] sel;
  logic wr, rd_setup, mode_wr;
  logic [1:0] tsrc;
  logic tick, pin_evt, tmr_hit, low_pwr;
  logic [31:0] rd_word [8];

  function automatic logic [7:0] reg_dec(input logic [11:0] a);
    reg_dec = '0;
    if (a[11:5] == 7'h00 && a[1:0] == 2'h0) begin
      reg_dec[a[4:2]] = 1'b1;
    end
  endfunction

  function automatic pcw_pkg::pcw_state_t mode_state(input logic [2:0] m);
    case (m)
      `PCW_MC_IDLE: mode_state = pcw_pkg::PCW_IDLE;
      `PCW_MC_SLP: mode_state = pcw_pkg::PCW_SLP;
      `PCW_MC_PWDN: mode_state = pcw_pkg::PCW_PWDN;
      `PCW_MC_XPWDN: mode_state = pcw_pkg::PCW_XPWDN;
      `PCW_MC_DOFF: mode_state = pcw_pkg::PCW_DOFF;
      default: mode_state = pcw_pkg::PCW_ACT;
    endcase
  endfunction

  // Power and clock enables per state; the always-on pin domain is outside
  function automatic pcw_pkg::pcw_pwr_t pwr_map(input pcw_pkg::pcw_state_t s);
    pwr_map = '0;
    case (s)
      pcw_pkg::PCW_ACT: pwr_map = 12'hbef;
      pcw_pkg::PCW_IDLE: pwr_map = 12'h7ef;
      pcw_pkg::PCW_SLP: pwr_map = 12'h45f;
      pcw_pkg::PCW_PWDN: pwr_map = 12'h073;
      pcw_pkg::PCW_XPWDN: pwr_map = 12'h071;
      pcw_pkg::PCW_DOFF: pwr_map = 12'h000;
      default: pwr_map = 12'hbef;
    endcase
  endfunction

  // APB decode
  assign sel = reg_dec(PADDR_I);
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && sel != 8'h00;
  assign rd_setup = PSEL_I && !PENABLE_I;
  assign mode_wr = wr && sel[0];
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && sel == 8'h00;
  assign PRDATA_O = rdata_reg;

  // Input synchronisers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      osc_s1_reg <= '0;
      osc_s2_reg <= '0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= {EXTERNAL_SLOW_CRYSTAL_I, HIGH_ACCURACY_INTERNAL_OSC_I,
                     LOW_CURRENT_INTERNAL_OSC_I};
      osc_s2_reg <= osc_s1_reg;
      pin_s1_reg <= WAKE_PIN_I;
      pin_s2_reg <= pin_s1_reg;
      lock_s1_reg <= LOCKOUT_I;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  // Deep-off has no internal oscillator, so the external input keeps time
  assign tsrc = state_reg == pcw_pkg::PCW_DOFF ? pcw_pkg::PCW_SRC_EXT
                                               : clk_reg[`PCW_CLK_SRC];
  assign tick = osc_s2_reg[tsrc] && !tick_prev_reg;
  assign pin_evt = |(pin_s2_reg & ~pin_prev_reg & pmsk_reg);
  assign low_pwr = !(state_reg inside {pcw_pkg::PCW_ACT, pcw_pkg::PCW_IDLE});
  assign tmr_hit = low_pwr && tick && wivl_reg != 32'h0
                   && tmr_reg == wivl_reg - 32'h1;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tick_prev_reg <= 1'b0;
      pin_prev_reg <= '0;
    end else begin
      tick_prev_reg <= osc_s2_reg[tsrc];
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // Wake interval timer, restarted on every entry into a low-power state
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || !low_pwr) begin
      tmr_reg <= '0;
    end else if (tick) begin
      tmr_reg <= tmr_reg + 32'h1;
    end
  end

  // Power state machine: entries only by firmware write, exits by wake events
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pcw_pkg::PCW_ACT: begin
        if (mode_wr) begin
          state_next = mode_state(PWDATA_I[2:0]);
        end
      end
      pcw_pkg::PCW_IDLE: begin
        if (IRQ_PEND_I || pin_evt || wif.irq) begin
          state_next = pcw_pkg::PCW_ACT;
        end
      end
      pcw_pkg::PCW_SLP, pcw_pkg::PCW_PWDN, pcw_pkg::PCW_XPWDN, pcw_pkg::PCW_DOFF: begin
        if (pin_evt || tmr_hit) begin
          state_next = pcw_pkg::PCW_ACT;
        end
      end
      default: state_next = pcw_pkg::PCW_ACT;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= pcw_pkg::PCW_ACT;
      pwr_reg <= 12'hbef;
      div_reg <= 4'h1;
    end else begin
      state_reg <= state_next;
      pwr_reg <= pwr_map(state_next);
      div_reg <= state_next == pcw_pkg::PCW_IDLE ? clk_reg[`PCW_CLK_DIV] : 4'h1;
    end
  end

  // Deep-off exit flag and wake cause survive until software clears them
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wake_reg <= '0;
      init_reg <= 1'b0;
    end else begin
      init_reg <= state_reg == pcw_pkg::PCW_DOFF && state_next == pcw_pkg::PCW_ACT;
      if (low_pwr && state_next == pcw_pkg::PCW_ACT) begin
        wake_reg <= (wake_reg & ~(wr && sel[6] ? PWDATA_I[2:0] : 3'h0))
                    | {tmr_hit, pin_evt, state_reg == pcw_pkg::PCW_DOFF};
      end else if (wr && sel[6]) begin
        wake_reg <= wake_reg & ~PWDATA_I[2:0];
      end
    end
  end

  // Software registers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode_reg <= `PCW_MC_ACT;
      clk_reg <= `PCW_CLK_RST;
      wivl_reg <= '0;
      pmsk_reg <= '0;
    end else if (wr) begin
      if (sel[0]) begin
        mode_reg <= PWDATA_I[2:0];
      end
      if (sel[2]) begin
        clk_reg <= PWDATA_I[7:0];
      end
      if (sel[3]) begin
        wivl_reg <= PWDATA_I;
      end
      if (sel[7]) begin
        pmsk_reg <= PWDATA_I[NPIN-1:0];
      end
    end
  end

  // Debug memory access starts off and stays off while lockout is present
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      dbg_reg <= 1'b0;
      blk_reg <= 1'b0;
    end else begin
      blk_reg <= lock_s2_reg;
      if (lock_s2_reg) begin
        dbg_reg <= 1'b0;
      end else if (wr && sel[5]) begin
        dbg_reg <= PWDATA_I[0];
      end
    end
  end

  // Read data is captured in the setup phase, valid for the access phase
  assign rd_word[0] = {29'h0, mode_reg};
  assign rd_word[1] = {24'h0, wif.irq, lock_s2_reg, state_reg};
  assign rd_word[2] = {24'h0, clk_reg};
  assign rd_word[3] = wivl_reg;
  assign rd_word[4] = {{(32 - `PCW_WDT_W){1'b0}}, wif.count};
  assign rd_word[5] = {30'h0, lock_s2_reg, dbg_reg};
  assign rd_word[6] = {29'h0, wake_reg};
  assign rd_word[7] = {{(32 - NPIN){1'b0}}, pmsk_reg};

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= '0;
    end else if (rd_setup) begin
      rdata_reg <= '0;
      for (int i = 0; i < 8; i++) begin
        if (sel[i]) begin
          rdata_reg <= rd_word[i];
        end
      end
    end
  end

  // Watchdog runs only in the active and idle states
  assign wif.run = state_reg inside {pcw_pkg::PCW_ACT, pcw_pkg::PCW_IDLE};
  assign wif.kick = wr && sel[4] && PWDATA_I[0];

  pcw_wdt #(
    .IRQ_CYC(WDT_IRQ_CYC),
    .RST_CYC(WDT_RST_CYC)
  ) u_wdt (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .w(wif.wdt)
  );

  // Outputs
  assign CPU_RUN_O = pwr_reg.run;
  assign WAIT_FOR_INTERRUPT_STATE_O = pwr_reg.wait_irq;
  assign PERIPH_EN_O = pwr_reg.per;
  assign HCLK_EN_O = pwr_reg.hclk;
  assign HCLK_DIV_O = div_reg;
  assign XTAL_EN_O = pwr_reg.xtal;
  assign SLOW_CLOCK_SEL_O = clk_reg[`PCW_CLK_SRC];
  assign EXT_BYPASS_O = clk_reg[`PCW_CLK_BYP];
  assign LP_OSC_EN_O = pwr_reg.lpo && clk_reg[`PCW_CLK_SRC] == pcw_pkg::PCW_SRC_LP;
  assign HP_OSC_EN_O = pwr_reg.lpo && clk_reg[`PCW_CLK_SRC] == pcw_pkg::PCW_SRC_HP;
  assign EXT_OSC_EN_O = state_reg == pcw_pkg::PCW_DOFF
                        || clk_reg[`PCW_CLK_SRC] == pcw_pkg::PCW_SRC_EXT;
  assign RTC_EN_O = pwr_reg.rtc;
  assign CACHE_EN_O = pwr_reg.core && CACHE_BYTES != 0;
  assign REG_LOWV_O = pwr_reg.lowv;
  assign RADIO_PWR_O = pwr_reg.radio;
  assign CORE_PWR_O = pwr_reg.core;
  assign RET_PWR_O = pwr_reg.ret;
  assign RAM_PWR_O = pwr_reg.ram;
  assign FULL_INIT_O = init_reg;
  assign WDT_IRQ_O = wif.irq;
  assign WDT_RST_O = wif.rst;
  assign DBG_MEM_EN_O = dbg_reg;
  assign HCI_RAW_BLOCK_O = blk_reg;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_doff_exit;
    state_reg == pcw_pkg::PCW_DOFF ##1 state_reg == pcw_pkg::PCW_ACT;
  endsequence

  doff_exit_flag_a: assert property (s_doff_exit |-> wake_reg[0] && FULL_INIT_O)
    else $error("deep-off exit not recorded");
  doff_osc_off_a: assert property (state_reg == pcw_pkg::PCW_DOFF |->
      !LP_OSC_EN_O && !HP_OSC_EN_O && !RTC_EN_O && !CORE_PWR_O && !RADIO_PWR_O)
    else $error("deep-off left a domain on");
  sleep_wake_a: assert property (low_pwr && pin_evt |=> state_reg == pcw_pkg::PCW_ACT)
    else $error("pin event did not wake");
  fw_entry_a: assert property (low_pwr && !$past(low_pwr) |->
      $past(state_reg) == pcw_pkg::PCW_ACT && $past(mode_wr))
    else $error("low-power entry without firmware");
  idle_clk_a: assert property (state_reg == pcw_pkg::PCW_IDLE |->
      WAIT_FOR_INTERRUPT_STATE_O && HCLK_EN_O && HCLK_DIV_O == clk_reg[7:4])
    else $error("idle clocking wrong");
  sleep_clk_a: assert property (state_reg == pcw_pkg::PCW_SLP |->
      !HCLK_EN_O && !XTAL_EN_O && REG_LOWV_O && RAM_PWR_O)
    else $error("sleep clocking wrong");
  lock_dbg_a: assert property (lock_s2_reg |=> !DBG_MEM_EN_O && HCI_RAW_BLOCK_O)
    else $error("lockout did not block debug");
endmodule // pcw_ctrl

/* File: hdl/pcw_pkg.sv */
/* Types of the power, clock and watchdog controller.
   Assumes nothing beyond a SystemVerilog compiler. */
package pcw_pkg;
  typedef enum logic [5:0] {
    PCW_ACT = 6'h01,
    PCW_IDLE = 6'h02,
    PCW_SLP = 6'h04,
    PCW_PWDN = 6'h08,
    PCW_XPWDN = 6'h10,
    PCW_DOFF = 6'h20
  } pcw_state_t;
  typedef enum logic [1:0] {
    PCW_SRC_LP = 2'h0,
    PCW_SRC_HP = 2'h1,
    PCW_SRC_EXT = 2'h2
  } pcw_src_t;
  typedef struct packed {
    logic run;
    logic wait_irq;
    logic per;
    logic hclk;
    logic xtal;
    logic lpo;
    logic rtc;
    logic lowv;
    logic radio;
    logic core;
    logic ret;
    logic ram;
  } pcw_pwr_t;
endpackage

/* File: hdl/pcw_wdt.sv */
/* Two-stage watchdog counter: interrupt level, then a one-cycle reset pulse.
   Assumes kick and run come from logic on the same clock. */
`timescale 1ns/1ps
`include "pcw_cfg.svh"
module pcw_wdt #(
  parameter int unsigned IRQ_CYC = `PCW_WDT_IRQ_MS * `PCW_CLK_MHZ * 1000,
  parameter int unsigned RST_CYC = `PCW_WDT_RST_MS * `PCW_CLK_MHZ * 1000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  pcw_wdt_if.wdt w
);
  localparam logic [`PCW_WDT_W-1:0] IRQ_C = `PCW_WDT_W'(IRQ_CYC);
  localparam logic [`PCW_WDT_W-1:0] RST_C = `PCW_WDT_W'(RST_CYC);
  logic [`PCW_WDT_W-1:0] cnt_reg, cnt_next;
  logic irq_reg;
  logic rst_reg;

  always_comb begin
    cnt_next = cnt_reg;
    if (w.kick) begin
      cnt_next = '0;
    end else if (w.run && cnt_reg != RST_C) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      irq_reg <= 1'b0;
      rst_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      irq_reg <= cnt_next >= IRQ_C;
      rst_reg <= cnt_next == RST_C && cnt_reg != RST_C;
    end
  end

  assign w.irq = irq_reg;
  assign w.rst = rst_reg;
  assign w.count = cnt_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  kick_clears_a: assert property (w.kick |=> cnt_reg == '0 && !irq_reg)
    else $error("watchdog count not restarted by service");
  irq_point_a: assert property ($rose(irq_reg) |-> cnt_reg == IRQ_C)
    else $error("watchdog interrupt at wrong count");
  rst_point_a: assert property (rst_reg |-> cnt_reg == RST_C && irq_reg ##1 !rst_reg)
    else $error("watchdog reset pulse wrong");
endmodule // pcw_wdt

/* File: hdl/pcw_wdt_if.sv */
/* Carrier between the controller and its watchdog counter.
   Assumes both ends share CLK_I. */
`timescale 1ns/1ps
`include "pcw_cfg.svh"
interface pcw_wdt_if;
  logic run;
  logic kick;
  logic irq;
  logic rst;
  logic [`PCW_WDT_W-1:0] count;
  modport ctl (output run, output kick, input irq, input rst, input count);
  modport wdt (input run, input kick, output irq, output rst, output count);
endinterface

/* File: tb/pcw_far_side.sv */
/* Far-side model: the three slow clock sources and the wake pins.
   Assumes the bench calls pulse_pin and shares clk_i with the design. */
`timescale 1ns/1ps
module pcw_far_side #(
  parameter int NPIN = 4
) (
  // Clock
  input wire logic clk_i,
  // Slow sources and pins
  output logic lp_osc_o,
  output logic hp_osc_o,
  output logic ext_osc_o,
  output logic [NPIN-1:0] pin_o
);
  // Free running, unrelated in phase to clk_i; a 76 ns period is 19 system cycles
  initial begin
    lp_osc_o = 1'b0;
    forever #38 lp_osc_o = ~lp_osc_o;
  end
  initial begin
    hp_osc_o = 1'b0;
    forever #41 hp_osc_o = ~hp_osc_o;
  end
  initial begin
    ext_osc_o = 1'b0;
    forever #47 ext_osc_o = ~ext_osc_o;
  end
  initial pin_o = '0;
  // Held for several cycles so the two-stage synchroniser cannot miss the edge
  task automatic pulse_pin(input int n);
    @(posedge clk_i);
    pin_o[n] <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin_o[n] <= 1'b0;
  endtask
endmodule // pcw_far_side

/* File: tb/testbench.sv */
/* Self-checking bench of the power, clock and watchdog controller.
   Assumes short watchdog counts (20 and 40 cycles) and the far-side model. */
`timescale 1ns/1ps
`include "pcw_cfg.svh"
module testbench;
  logic clk, rst, psel, pen, pwr, irq_pend, lockout, pready, pslverr, lp, hp, ext;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [3:0] pins, hdiv;
  logic [1:0] ssel;
  logic run, wait_st, per, hclk, xtal, lpen, hpen, exten, rtc, cache, lowv, radio, core;
  logic ret, ram, finit, byp, wirq, wrst, dbg, rawblk, seen_init;
  logic [32:0] expq[$];
  int n_fail, n_checks, cyc, p, n, t;

  pcw_ctrl #(.NPIN(4), .WDT_IRQ_CYC(20), .WDT_RST_CYC(40)) u_pcw_ctrl (
    .CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .LOW_CURRENT_INTERNAL_OSC_I(lp),
    .HIGH_ACCURACY_INTERNAL_OSC_I(hp), .EXTERNAL_SLOW_CRYSTAL_I(ext),
    .WAKE_PIN_I(pins), .IRQ_PEND_I(irq_pend), .LOCKOUT_I(lockout), .CPU_RUN_O(run),
    .WAIT_FOR_INTERRUPT_STATE_O(wait_st), .PERIPH_EN_O(per), .HCLK_EN_O(hclk),
    .HCLK_DIV_O(hdiv), .XTAL_EN_O(xtal), .SLOW_CLOCK_SEL_O(ssel), .EXT_BYPASS_O(byp),
    .LP_OSC_EN_O(lpen), .HP_OSC_EN_O(hpen), .EXT_OSC_EN_O(exten), .RTC_EN_O(rtc),
    .CACHE_EN_O(cache), .REG_LOWV_O(lowv), .RADIO_PWR_O(radio), .CORE_PWR_O(core),
    .RET_PWR_O(ret), .RAM_PWR_O(ram), .FULL_INIT_O(finit), .WDT_IRQ_O(wirq),
    .WDT_RST_O(wrst), .DBG_MEM_EN_O(dbg), .HCI_RAW_BLOCK_O(rawblk));

  pcw_far_side #(.NPIN(4)) u_pcw_far_side (
    .clk_i(clk), .lp_osc_o(lp), .hp_osc_o(hp), .ext_osc_o(ext), .pin_o(pins));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wait_run(input int lim);
    n = 0;
    while (run !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(run, 1);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Read completions are judged against the oldest note of the driver
  always @(posedge clk) begin
    if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1 && pwr === 1'b0) begin
      if (expq.size() > 0) begin
        chk({pslverr, prdata}, expq.pop_front());
      end else begin
        n_fail++;
        $display("[FAIL] %0t read without an expected value", $time);
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (finit === 1'b1)
      seen_init = 1'b1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    {psel, pen, pwr, irq_pend, lockout, seen_init} = '0;
    paddr = '0;
    pwdata = '0;
    {n_fail, n_checks, cyc} = '0;
    rnd = 32'hf8961abb;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`PCW_A_MODE, 33'h0);
    rd(`PCW_A_CLK, 33'h42);
    rd(`PCW_A_WAKE, 33'h0);
    rd(12'h020, 33'h100000000);
    rd(12'h006, 33'h100000000);
    settle(1);
    chk({run, wait_st, per, xtal, cache, dbg}, 33'b101110);
    done("reset");
    for (int s = 0; s < 3; s++) begin
      wr(`PCW_A_CLK, 32'(32'h40 + s + ((s == 2) ? 4 : 0)));
      rd(`PCW_A_CLK, 33'(32'h40 + s + ((s == 2) ? 4 : 0)));
      settle(1);
      chk(ssel, 33'(s));
      chk({lpen, hpen, exten, byp}, 33'((8 >> s) + ((s == 2) ? 1 : 0)));
    end
    wr(`PCW_A_CLK, 32'h42);
    done("clock select");
    wr(`PCW_A_WDOG, 32'h1);
    wr(`PCW_A_MODE, 32'h1);
    settle(3);
    chk({run, wait_st, per, hclk, xtal}, 33'b01111);
    chk(hdiv, 33'h4);
    @(posedge clk);
    irq_pend <= 1'b1;
    @(posedge clk);
    irq_pend <= 1'b0;
    settle(4);
    chk({run, hdiv}, 33'h11);
    done("idle");
    wr(`PCW_A_WDOG, 32'h1);
    settle(12);
    chk(wirq, 0);
    wr(`PCW_A_WDOG, 32'h1);
    settle(15);
    chk(wirq, 0);
    n = 0;
    while (wirq !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(wirq, 1);
    wr(`PCW_A_WDOG, 32'h1);
    settle(1);
    chk(wirq, 0);
    n = 1;
    while (wrst !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 38 && n <= 42, 1);
    done("watchdog");
    rnd = xs(rnd);
    p = int'(rnd[1:0]);
    wr(`PCW_A_PMSK, 32'h1 << p);
    wr(`PCW_A_MODE, 32'h2);
    settle(3);
    chk({run, wait_st, hclk, xtal, rtc, lowv, core, ret, ram}, 33'b010001111);
    u_pcw_far_side.pulse_pin((p + 1) % 4);
    settle(8);
    chk(run, 0);
    u_pcw_far_side.pulse_pin(p);
    wait_run(20);
    rd(`PCW_A_WAKE, 33'h2);
    wr(`PCW_A_WAKE, 32'h7);
    done("sleep");
    rnd = xs(rnd);
    // At least two ticks, so the wake cannot land before the enables are checked
    t = int'(rnd[1:0]) + 2;
    wr(`PCW_A_CLK, 32'h40);
    wr(`PCW_A_WIVL, 32'(t));
    wr(`PCW_A_PMSK, 32'h0);
    wr(`PCW_A_MODE, 32'h3);
    settle(3);
    chk({radio, core, ret, ram, rtc, lpen, hpen, cache}, 33'b00111100);
    wait_run(t * 19 + 40);
    chk(n + 3 >= (t - 1) * 19 && n <= t * 19 + 8, 1);
    rd(`PCW_A_WAKE, 33'h4);
    wr(`PCW_A_WAKE, 32'h7);
    wr(`PCW_A_WIVL, 32'h0);
    done("power-down sleep");
    rnd = xs(rnd);
    p = int'(rnd[1:0]);
    wr(`PCW_A_PMSK, {28'h0, rnd[7:4]} | (32'h1 << p));
    wr(`PCW_A_MODE, 32'h4);
    settle(3);
    chk({radio, core, ret, ram, lpen}, 33'b00011);
    u_pcw_far_side.pulse_pin(p);
    wait_run(20);
    rd(`PCW_A_WAKE, 33'h2);
    wr(`PCW_A_WAKE, 32'h7);
    done("extended sleep");
    wr(`PCW_A_MODE, 32'h5);
    settle(3);
    chk({core, radio, lowv, ram, lpen, hpen, rtc, exten}, 33'b00000001);
    seen_init = 1'b0;
    u_pcw_far_side.pulse_pin(p);
    wait_run(20);
    settle(2);
    chk(seen_init, 1);
    rd(`PCW_A_WAKE, 33'h3);
    u_pcw_far_side.pulse_pin(p);
    settle(8);
    wr(`PCW_A_WDOG, 32'h1);
    rd(`PCW_A_STAT, 33'h1);
    done("deep off");
    wr(`PCW_A_LOCK, 32'h1);
    settle(1);
    chk(dbg, 1);
    @(posedge clk);
    lockout <= 1'b1;
    settle(5);
    chk({dbg, rawblk}, 33'b01);
    wr(`PCW_A_WDOG, 32'h1);
    rd(`PCW_A_STAT, 33'h41);
    settle(2);
    done("lockout");
    print_verdict();
  end
endmodule // testbench
